//--- inc/swr_link_if.sv
// Open-drain data line and interrupt line between device and master
interface swr_link_if;
	logic dev_dq_oe;
	logic dev_dq_out;
	logic host_dq_oe;
	logic host_dq_out;
	logic dq;
	logic dev_int_oe;
	logic dev_int_out;
	logic int_n;

	// Pull-up wins unless someone pulls low
	assign dq    = ~((dev_dq_oe & ~dev_dq_out) | (host_dq_oe & ~host_dq_out));
	assign int_n = ~(dev_int_oe & ~dev_int_out);

	modport dev  (input dq, output dev_dq_oe, output dev_dq_out,
		output dev_int_oe, output dev_int_out);
	modport host (input dq, input int_n, output host_dq_oe,
		output host_dq_out);
endinterface

//--- inc/swr_pkg.sv
// Shared constants, types and check-value helpers of the single-wire link
// Overview of operation
// - Device holds fixed 64-bit identity code
// - Low eight bits are family code
// - Next 48 bits are serial number
// - Top byte checks preceding 56 bits
// - Check shift register uses x8+x5+x4+1
// - Check register cleared before first bit
// - Feed family LSB first, then serial
// - After serial, register equals stored check
// - Receiver shifts check too, expects zero
// - All data moves least significant bit first
// - Master sends ROM command before clock commands
// - Device accepts clock commands after ROM command
// - Data pin only pulls low or releases
// - Interrupt pin is open-drain, pulls low
// - Bit rate at most 16.3k per second
// - Time base from 32.768 kHz crystal
// - Time kept as binary seconds count
// - Programmable interrupt wakes the host
// - Reset pulse then presence pulse first
// - ROM command codes are eight bits
// - Read-identity 33h sends whole code
package swr_pkg;

	// ****************************************
	// Timing, in microseconds, and clock rate
	// ****************************************
	localparam int CLK_MHZ        = 25;
	localparam int T_RST_US       = 480;
	localparam int T_RST_DET_US   = 300;
	localparam int T_PRES_DLY_US  = 30;
	localparam int T_PRES_US      = 120;
	localparam int T_PRES_SMP_US  = 70;
	localparam int T_LOW1_US      = 6;
	localparam int T_LOW0_US      = 60;
	localparam int T_HSMP_US      = 13;
	localparam int T_DSMP_US      = 30;
	localparam int T_SLOT_US      = 70;
	localparam int T_REC_US       = 2;
	localparam int T_INT_US       = 1000;
	localparam int XTAL_HZ        = 32768;

	localparam int CNT_RST        = T_RST_US * CLK_MHZ;
	localparam int CNT_RST_DET    = T_RST_DET_US * CLK_MHZ;
	localparam int CNT_PRES_DLY   = T_PRES_DLY_US * CLK_MHZ;
	localparam int CNT_PRES       = T_PRES_US * CLK_MHZ;
	localparam int CNT_PRES_SMP   = T_PRES_SMP_US * CLK_MHZ;
	localparam int CNT_LOW1       = T_LOW1_US * CLK_MHZ;
	localparam int CNT_LOW0       = T_LOW0_US * CLK_MHZ;
	localparam int CNT_HSMP       = T_HSMP_US * CLK_MHZ;
	localparam int CNT_DSMP       = T_DSMP_US * CLK_MHZ;
	localparam int CNT_SLOT       = (T_SLOT_US + T_REC_US) * CLK_MHZ;
	localparam int CNT_INT        = T_INT_US * CLK_MHZ;
	localparam int CNT_W          = 16;

	// ****************************************
	// Identity code layout and commands
	// ****************************************
	localparam int ID_BITS        = 64;
	localparam int FAM_BITS       = 8;
	localparam int SER_BITS       = 48;
	localparam int BODY_BITS      = FAM_BITS + SER_BITS;
	localparam int BYTE_BITS      = 8;
	localparam int RSP_W          = ID_BITS + 1;
	localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
	localparam logic [7:0] CRC_INIT      = 8'h00;
	localparam logic [7:0] CMD_READ_ID   = 8'h33;
	localparam logic [7:0] CMD_MATCH     = 8'h55;
	localparam logic [7:0] CMD_SEARCH    = 8'hf0;
	localparam logic [7:0] CMD_SKIP      = 8'hcc;

	typedef enum logic [1:0] {
		OP_RESET, OP_WRITE, OP_READ, OP_READ_ID
	} swr_op_type;

	// One shift of the reflected x8+x5+x4+1 register
	function automatic logic [7:0] crc8_step(input logic [7:0] c,
		input logic b);
		logic fb;
		fb = c[0] ^ b;
		crc8_step = {1'b0, c[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00);
	endfunction

	function automatic logic [7:0] crc8_body(
		input logic [BODY_BITS-1:0] body);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 0; i < BODY_BITS; i++) begin
			c = crc8_step(c, body[i]);
		end
		crc8_body = c;
	endfunction

	function automatic logic is_rom_cmd(input logic [7:0] c);
		is_rom_cmd = (c == CMD_READ_ID) || (c == CMD_MATCH) ||
			(c == CMD_SEARCH) || (c == CMD_SKIP);
	endfunction

	// Interval exponent: 1, 4, 32, 64, 2048, 4096, 65536, 131072 s
	function automatic logic [4:0] int_exp(input logic [2:0] sel);
		logic [4:0] e;
		unique case (sel)
			3'h0: e = 5'h00;
			3'h1: e = 5'h02;
			3'h2: e = 5'h05;
			3'h3: e = 5'h06;
			3'h4: e = 5'h0b;
			3'h5: e = 5'h0c;
			3'h6: e = 5'h10;
			3'h7: e = 5'h11;
		endcase
		int_exp = e;
	endfunction

endpackage

//--- rtl/swr_dev.sv
// Device end: identity code, ROM-level commands, seconds count, interrupt
module swr_dev #(
	// Arbitrary identity values, not those of any real part
	parameter logic [7:0]  FAMILY       = 8'h5a,
	parameter logic [47:0] SERIAL       = 48'h0000_1234_5678,
	parameter int          CNT_RST_DET  = swr_pkg::CNT_RST_DET,
	parameter int          CNT_PRES_DLY = swr_pkg::CNT_PRES_DLY,
	parameter int          CNT_PRES     = swr_pkg::CNT_PRES,
	parameter int          CNT_DSMP     = swr_pkg::CNT_DSMP,
	parameter int          XTAL_HZ      = swr_pkg::XTAL_HZ,
	parameter int          CNT_INT      = swr_pkg::CNT_INT
) (
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	swr_link_if.dev         link,
	input  wire logic       i_crystal_in_pin,
	input  wire logic       i_int_en,
	input  wire logic [2:0] i_int_sel,
	output logic            o_crystal_out_pin,
	output logic            o_rom_ok,
	output logic            o_func_valid,
	output logic [7:0]      o_func_cmd,
	output logic [31:0]     o_seconds
);
	localparam int CW = swr_pkg::CNT_W;
	localparam int BW = 6;

	// Fixed at build time; nothing on the line can alter it
	localparam logic [63:0] ROM_ID = {
		swr_pkg::crc8_body({SERIAL, FAMILY}),
		SERIAL,
		FAMILY
	};

	typedef enum logic [3:0] {
		ST_IDLE, ST_PRES_DLY, ST_PRES, ST_ROM_CMD, ST_ROM_READ,
		ST_ROM_MATCH, ST_ROM_SEARCH, ST_FUNC_CMD, ST_DONE
	} swr_dst_type;

	swr_dst_type   st_q, st_d;
	logic [CW-1:0] tmr_q, tmr_d, low_q, low_d;
	logic [BW-1:0] bit_q, bit_d;
	logic [1:0]    ph_q, ph_d;
	logic [7:0]    sh_q, sh_d, fc_q, fc_d, nb;
	logic          slot_q, slot_d, oe_q, oe_d, ok_q, ok_d, fv_q, fv_d;
	logic          prev_q, fall, rise, sample, tx, rx, rbit, lastb;

	// ****************************************
	// Line sequencing
	// ****************************************
	always_comb begin
		st_d   = st_q;
		tmr_d  = tmr_q;
		bit_d  = bit_q;
		ph_d   = ph_q;
		sh_d   = sh_q;
		slot_d = slot_q;
		oe_d   = oe_q;
		ok_d   = ok_q;
		fv_d   = 1'b0;
		fc_d   = fc_q;
		fall   = prev_q & ~link.dq;
		rise   = ~prev_q & link.dq;
		low_d  = link.dq ? '0 :
			((low_q == CW'(CNT_RST_DET)) ? low_q : low_q + CW'(1));
		sample = slot_q && (tmr_q == CW'(CNT_DSMP - 1));
		rbit   = ROM_ID[bit_q];
		lastb  = bit_q == BW'(swr_pkg::ID_BITS - 1);
		nb     = {link.dq, sh_q[7:1]};
		tx     = 1'b1;
		rx     = 1'b0;
		if (slot_q) begin
			tmr_d = tmr_q + CW'(1);
		end
		unique case (st_q)
			ST_IDLE, ST_DONE: ;
			ST_PRES_DLY: begin
				tmr_d = tmr_q + CW'(1);
				if (tmr_q == CW'(CNT_PRES_DLY - 1)) begin
					oe_d  = 1'b1;
					tmr_d = '0;
					st_d  = ST_PRES;
				end
			end
			ST_PRES: begin
				tmr_d = tmr_q + CW'(1);
				if (tmr_q == CW'(CNT_PRES - 1)) begin
					oe_d  = 1'b0;
					bit_d = '0;
					sh_d  = 8'h00;
					st_d  = ST_ROM_CMD;
				end
			end
			ST_ROM_CMD: begin
				rx = 1'b1;
				if (sample) begin
					sh_d  = nb;
					bit_d = bit_q + BW'(1);
					if (bit_q == BW'(swr_pkg::BYTE_BITS - 1)) begin
						bit_d = '0;
						ph_d  = 2'h0;
						st_d  = ST_IDLE;
						if (nb == swr_pkg::CMD_READ_ID) begin
							st_d = ST_ROM_READ;
						end else if (nb == swr_pkg::CMD_MATCH) begin
							st_d = ST_ROM_MATCH;
						end else if (nb == swr_pkg::CMD_SEARCH) begin
							st_d = ST_ROM_SEARCH;
						end else if (nb == swr_pkg::CMD_SKIP) begin
							ok_d = 1'b1;
							st_d = ST_FUNC_CMD;
						end
					end
				end
			end
			ST_ROM_READ: begin
				tx = rbit;
				if (sample) begin
					bit_d = bit_q + BW'(1);
					if (lastb) begin
						ok_d = 1'b1;
						st_d = ST_FUNC_CMD;
					end
				end
			end
			ST_ROM_MATCH: begin
				rx = 1'b1;
				if (sample) begin
					bit_d = bit_q + BW'(1);
					if (link.dq != rbit) begin
						st_d = ST_IDLE;
					end else if (lastb) begin
						ok_d = 1'b1;
						st_d = ST_FUNC_CMD;
					end
				end
			end
			ST_ROM_SEARCH: begin
				// Bit, its complement, then the master's choice
				tx = (ph_q == 2'h0) ? rbit : ~rbit;
				rx = ph_q == 2'h2;
				if (sample) begin
					ph_d = ph_q + 2'h1;
					if (rx) begin
						ph_d  = 2'h0;
						bit_d = bit_q + BW'(1);
						if (link.dq != rbit) begin
							st_d = ST_IDLE;
						end else if (lastb) begin
							ok_d = 1'b1;
							st_d = ST_FUNC_CMD;
						end
					end
				end
			end
			ST_FUNC_CMD: begin
				rx = 1'b1;
				if (sample && ok_q) begin
					sh_d  = nb;
					bit_d = bit_q + BW'(1);
					if (bit_q == BW'(swr_pkg::BYTE_BITS - 1)) begin
						fv_d = 1'b1;
						fc_d = nb;
						st_d = ST_DONE;
					end
				end
			end
		endcase
		if (fall && (rx || st_q == ST_ROM_READ || st_q == ST_ROM_SEARCH)) begin
			slot_d = 1'b1;
			tmr_d  = '0;
			oe_d   = ~rx & ~tx;
		end
		if (sample) begin
			slot_d = 1'b0;
			oe_d   = 1'b0;
		end
		// A long low pulse aborts anything and starts a new transaction
		if (rise && low_q == CW'(CNT_RST_DET)) begin
			st_d   = ST_PRES_DLY;
			tmr_d  = '0;
			slot_d = 1'b0;
			oe_d   = 1'b0;
			ok_d   = 1'b0;
			bit_d  = '0;
			ph_d   = 2'h0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st_q   <= ST_IDLE;
			tmr_q  <= '0;
			low_q  <= '0;
			bit_q  <= '0;
			ph_q   <= 2'h0;
			sh_q   <= 8'h00;
			slot_q <= 1'b0;
			oe_q   <= 1'b0;
			ok_q   <= 1'b0;
			fv_q   <= 1'b0;
			fc_q   <= 8'h00;
			prev_q <= 1'b1;
		end else begin
			st_q   <= st_d;
			tmr_q  <= tmr_d;
			low_q  <= low_d;
			bit_q  <= bit_d;
			ph_q   <= ph_d;
			sh_q   <= sh_d;
			slot_q <= slot_d;
			oe_q   <= oe_d;
			ok_q   <= ok_d;
			fv_q   <= fv_d;
			fc_q   <= fc_d;
			prev_q <= link.dq;
		end
	end

	// ****************************************
	// Seconds count and interrupt
	// ****************************************
	logic [15:0]   div_q, div_d;
	logic [31:0]   sec_q, sec_d, mask;
	logic [CW-1:0] ic_q, ic_d;
	logic          xp_q, xo_q, xo_d, ioe_q, ioe_d;

	always_comb begin
		div_d = div_q;
		sec_d = sec_q;
		ic_d  = (ic_q == '0) ? ic_q : ic_q - CW'(1);
		xo_d  = ~i_crystal_in_pin;
		mask  = (32'h1 << swr_pkg::int_exp(i_int_sel)) - 32'h1;
		if (i_crystal_in_pin && !xp_q) begin
			div_d = div_q + 16'h1;
			if (div_q == 16'(XTAL_HZ - 1)) begin
				div_d = '0;
				sec_d = sec_q + 32'h1;
				if (i_int_en && (sec_d & mask) == 32'h0) begin
					ic_d = CW'(CNT_INT);
				end
			end
		end
		ioe_d = ic_d != '0;
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			div_q <= 16'h0;
			sec_q <= 32'h0;
			ic_q  <= '0;
			xp_q  <= 1'b0;
			xo_q  <= 1'b1;
			ioe_q <= 1'b0;
		end else begin
			div_q <= div_d;
			sec_q <= sec_d;
			ic_q  <= ic_d;
			xp_q  <= i_crystal_in_pin;
			xo_q  <= xo_d;
			ioe_q <= ioe_d;
		end
	end

	assign link.dev_dq_oe   = oe_q;
	assign link.dev_dq_out  = 1'b0;
	assign link.dev_int_oe  = ioe_q;
	assign link.dev_int_out = 1'b0;
	assign o_crystal_out_pin = xo_q;
	assign o_rom_ok          = ok_q;
	assign o_func_valid      = fv_q;
	assign o_func_cmd        = fc_q;
	assign o_seconds         = sec_q;
endmodule

//--- rtl/swr_host.sv
// Bus master end: reset, byte and identity transfers over the line
module swr_host #(
	parameter int CNT_RST      = swr_pkg::CNT_RST,
	parameter int CNT_PRES_SMP = swr_pkg::CNT_PRES_SMP,
	parameter int CNT_LOW1     = swr_pkg::CNT_LOW1,
	parameter int CNT_LOW0     = swr_pkg::CNT_LOW0,
	parameter int CNT_HSMP     = swr_pkg::CNT_HSMP,
	parameter int CNT_SLOT     = swr_pkg::CNT_SLOT
) (
	input  wire logic                 i_mclk,
	input  wire logic                 i_sys_rst,
	swr_link_if.host                  link,
	input  wire logic                 i_req_valid,
	input  wire swr_pkg::swr_op_type  i_req_op,
	input  wire logic [7:0]           i_req_data,
	output logic                      o_req_ready,
	output logic                      o_rsp_valid,
	output logic                      o_rsp_ok,
	output logic [63:0]               o_rsp_data,
	input  wire logic                 i_rsp_ready,
	output logic                      o_int_active
);
	localparam int CW = swr_pkg::CNT_W;

	typedef enum logic [2:0] {
		H_IDLE, H_RST_LOW, H_RST_REL, H_SLOT, H_PUSH
	} swr_hst_type;

	swr_hst_type         st_q, st_d;
	swr_pkg::swr_op_type op_q, op_d;
	logic [CW-1:0]       tmr_q, tmr_d;
	logic [7:0]          cmd_q, cmd_d, crc_q, crc_d;
	logic [6:0]          bit_q, bit_d;
	logic [63:0]         rx_q, rx_d, push_data;
	logic                ok_q, ok_d, romd_q, romd_d, oe_q, oe_d;
	logic                rdy_q, rdy_d, int_q, int_d;
	logic                writing, last, buf_ready;

	// ****************************************
	// Master sequencing
	// ****************************************
	always_comb begin
		st_d    = st_q;
		op_d    = op_q;
		tmr_d   = tmr_q + CW'(1);
		cmd_d   = cmd_q;
		crc_d   = crc_q;
		bit_d   = bit_q;
		rx_d    = rx_q;
		ok_d    = ok_q;
		romd_d  = romd_q;
		oe_d    = oe_q;
		int_d   = ~link.int_n;
		writing = (op_q == swr_pkg::OP_WRITE) ||
			((op_q == swr_pkg::OP_READ_ID) && (bit_q < 7'(swr_pkg::BYTE_BITS)));
		last    = bit_q == ((op_q == swr_pkg::OP_READ_ID) ?
			7'(swr_pkg::BYTE_BITS + swr_pkg::ID_BITS - 1) :
			7'(swr_pkg::BYTE_BITS - 1));
		unique case (st_q)
			H_IDLE: begin
				tmr_d = '0;
				if (i_req_valid && rdy_q) begin
					op_d  = i_req_op;
					cmd_d = i_req_data;
					bit_d = '0;
					rx_d  = '0;
					crc_d = swr_pkg::CRC_INIT;
					ok_d  = 1'b1;
					oe_d  = 1'b1;
					st_d  = H_SLOT;
					unique case (i_req_op)
						swr_pkg::OP_RESET: st_d = H_RST_LOW;
						swr_pkg::OP_WRITE: begin
							if (!romd_q && !swr_pkg::is_rom_cmd(i_req_data)) begin
								ok_d = 1'b0;
								oe_d = 1'b0;
								st_d = H_PUSH;
							end else begin
								romd_d = 1'b1;
							end
						end
						swr_pkg::OP_READ: ;
						swr_pkg::OP_READ_ID: begin
							cmd_d  = swr_pkg::CMD_READ_ID;
							romd_d = 1'b1;
						end
					endcase
				end
			end
			H_RST_LOW: begin
				if (tmr_q == CW'(CNT_RST - 1)) begin
					oe_d  = 1'b0;
					tmr_d = '0;
					st_d  = H_RST_REL;
				end
			end
			H_RST_REL: begin
				if (tmr_q == CW'(CNT_PRES_SMP - 1)) begin
					ok_d = ~link.dq;
				end
				if (tmr_q == CW'(CNT_RST - 1)) begin
					romd_d = 1'b0;
					st_d   = H_PUSH;
				end
			end
			H_SLOT: begin
				if (tmr_q == CW'(CNT_LOW1 - 1) &&
					(!writing || cmd_q[bit_q[2:0]])) begin
					oe_d = 1'b0;
				end
				if (tmr_q == CW'(CNT_LOW0 - 1)) begin
					oe_d = 1'b0;
				end
				if (tmr_q == CW'(CNT_HSMP - 1) && !writing) begin
					rx_d  = {link.dq, rx_q[63:1]};
					crc_d = swr_pkg::crc8_step(crc_q, link.dq);
				end
				// Slot plus recovery keeps the rate below the limit
				if (tmr_q == CW'(CNT_SLOT - 1)) begin
					tmr_d = '0;
					if (last) begin
						if (op_q == swr_pkg::OP_READ_ID) begin
							ok_d = crc_q == 8'h00;
						end
						st_d = H_PUSH;
					end else begin
						bit_d = bit_q + 7'h01;
						oe_d  = 1'b1;
					end
				end
			end
			H_PUSH: begin
				if (buf_ready) begin
					st_d = H_IDLE;
				end
			end
		endcase
		rdy_d = st_d == H_IDLE;
	end

	always_comb begin
		unique case (op_q)
			swr_pkg::OP_READ:    push_data = {56'h0, rx_q[63:56]};
			swr_pkg::OP_READ_ID: push_data = ok_q ? rx_q : 64'h0;
			default:             push_data = 64'h0;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st_q   <= H_IDLE;
			op_q   <= swr_pkg::OP_RESET;
			tmr_q  <= '0;
			cmd_q  <= 8'h00;
			crc_q  <= 8'h00;
			bit_q  <= 7'h00;
			rx_q   <= 64'h0;
			ok_q   <= 1'b0;
			romd_q <= 1'b0;
			oe_q   <= 1'b0;
			rdy_q  <= 1'b0;
			int_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			op_q   <= op_d;
			tmr_q  <= tmr_d;
			cmd_q  <= cmd_d;
			crc_q  <= crc_d;
			bit_q  <= bit_d;
			rx_q   <= rx_d;
			ok_q   <= ok_d;
			romd_q <= romd_d;
			oe_q   <= oe_d;
			rdy_q  <= rdy_d;
			int_q  <= int_d;
		end
	end

	swr_skid #(
		.WIDTH (swr_pkg::RSP_W)
	) u_rsp_buf (
		.i_mclk      (i_mclk),
		.i_sys_rst   (i_sys_rst),
		.i_in_valid  (st_q == H_PUSH),
		.i_in_data   ({ok_q, push_data}),
		.o_in_ready  (buf_ready),
		.o_out_valid (o_rsp_valid),
		.o_out_data  ({o_rsp_ok, o_rsp_data}),
		.i_out_ready (i_rsp_ready)
	);

	assign link.host_dq_oe  = oe_q;
	assign link.host_dq_out = 1'b0;
	assign o_req_ready      = rdy_q;
	assign o_int_active     = int_q;
endmodule

//--- rtl/swr_skid.sv
// Two-entry valid/ready buffer whose outputs come from flip-flops
module swr_skid #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_mclk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	logic             out_v_q, out_v_d, sk_v_q, sk_v_d;
	logic [WIDTH-1:0] out_q, out_d, sk_q, sk_d;
	logic             drain;

	always_comb begin
		out_v_d = out_v_q;
		out_d   = out_q;
		sk_v_d  = sk_v_q;
		sk_d    = sk_q;
		drain   = ~out_v_q | i_out_ready;
		if (sk_v_q) begin
			if (drain) begin
				out_d   = sk_q;
				out_v_d = 1'b1;
				sk_v_d  = 1'b0;
			end
		end else if (i_in_valid) begin
			// Second entry catches a word while the head is stalled
			if (drain) begin
				out_d   = i_in_data;
				out_v_d = 1'b1;
			end else begin
				sk_d   = i_in_data;
				sk_v_d = 1'b1;
			end
		end else if (drain) begin
			out_v_d = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			out_v_q <= 1'b0;
			sk_v_q  <= 1'b0;
			out_q   <= '0;
			sk_q    <= '0;
		end else begin
			out_v_q <= out_v_d;
			sk_v_q  <= sk_v_d;
			out_q   <= out_d;
			sk_q    <= sk_d;
		end
	end

	assign o_in_ready  = ~sk_v_q;
	assign o_out_valid = out_v_q;
	assign o_out_data  = out_q;
endmodule

//--- testbench/single_wire_rom_id_crc_tb.sv
// Self-checking bench joining master and device ends
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module single_wire_rom_id_crc_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0]  FAM = 8'h3c;            // Arbitrary value
	localparam logic [47:0] SER = 48'h00a1_b2c3_d4e5; // Arbitrary value
	// Shortened line timing keeps the run under twenty thousand cycles
	localparam int          K_RST  = 400;
	localparam int          K_PSMP = 50;
	localparam int          K_LOW1 = 4;
	localparam int          K_LOW0 = 40;
	localparam int          K_HSMP = 10;
	localparam int          K_SLOT = 60;
	localparam int          K_RDET = 250;
	localparam int          K_PDLY = 20;
	localparam int          K_PRES = 80;
	localparam int          K_DSMP = 20;
	localparam int          K_XTAL = 4;
	localparam int          K_INT  = 10;
	typedef struct {
		swr_pkg::swr_op_type op;
		logic [7:0]          d;
		logic                ok;
		logic [1:0]          dsel;
		logic                rom;
		logic                fchk;
	} swr_row_type;
	logic mclk, rst, req_valid, rsp_rdy, int_en, req_ready, rsp_valid;
	logic rsp_ok, int_act, xo, rom_ok, func_valid, fseen, r_ok;
	logic [2:0]  xcnt, int_sel;
	logic [7:0]  req_data, func_cmd, last_func;
	logic [31:0] seconds;
	logic [63:0] rsp_data, r_data, id_exp;
	swr_pkg::swr_op_type req_op;
	int n_mismatch = 0;
	int num_checks = 0;
	swr_row_type rows [14] = '{
		'{swr_pkg::OP_RESET,   8'h00, 1, 0, 0, 0},
		'{swr_pkg::OP_WRITE,   8'h12, 0, 1, 0, 0},
		'{swr_pkg::OP_READ_ID, 8'h00, 1, 2, 1, 0},
		'{swr_pkg::OP_WRITE,   8'h66, 1, 0, 1, 1},
		'{swr_pkg::OP_READ_ID, 8'h00, 0, 1, 1, 0},
		'{swr_pkg::OP_RESET,   8'h00, 1, 0, 0, 0},
		'{swr_pkg::OP_WRITE,   8'hcc, 1, 0, 1, 0},
		'{swr_pkg::OP_WRITE,   8'h99, 1, 0, 1, 1},
		'{swr_pkg::OP_RESET,   8'h00, 1, 0, 0, 0},
		'{swr_pkg::OP_WRITE,   8'h55, 1, 0, 0, 0},
		'{swr_pkg::OP_READ,    8'h00, 1, 3, 0, 0},
		'{swr_pkg::OP_RESET,   8'h00, 1, 0, 0, 0},
		'{swr_pkg::OP_WRITE,   8'hf0, 1, 0, 0, 0},
		'{swr_pkg::OP_RESET,   8'h00, 1, 0, 0, 0}};

	swr_link_if lnk ();
	swr_host #(.CNT_RST(K_RST), .CNT_PRES_SMP(K_PSMP),
		.CNT_LOW1(K_LOW1), .CNT_LOW0(K_LOW0), .CNT_HSMP(K_HSMP),
		.CNT_SLOT(K_SLOT)) u_swr_host (
		.i_mclk(mclk), .i_sys_rst(rst), .link(lnk.host),
		.i_req_valid(req_valid), .i_req_op(req_op),
		.i_req_data(req_data), .o_req_ready(req_ready),
		.o_rsp_valid(rsp_valid), .o_rsp_ok(rsp_ok),
		.o_rsp_data(rsp_data), .i_rsp_ready(rsp_rdy),
		.o_int_active(int_act));
	swr_dev #(.FAMILY(FAM), .SERIAL(SER), .CNT_RST_DET(K_RDET),
		.CNT_PRES_DLY(K_PDLY), .CNT_PRES(K_PRES), .CNT_DSMP(K_DSMP),
		.XTAL_HZ(K_XTAL), .CNT_INT(K_INT)) u_swr_dev (
		.i_mclk(mclk), .i_sys_rst(rst), .link(lnk.dev),
		.i_crystal_in_pin(xcnt[2]), .i_int_en(int_en),
		.i_int_sel(int_sel), .o_crystal_out_pin(xo), .o_rom_ok(rom_ok),
		.o_func_valid(func_valid), .o_func_cmd(func_cmd),
		.o_seconds(seconds));
	swr_link_chk #(.CNT_RST(K_RST), .CNT_LOW1(K_LOW1), .CNT_LOW0(K_LOW0),
		.CNT_RST_DET(K_RDET), .CNT_PRES_DLY(K_PDLY), .CNT_PRES(K_PRES),
		.CNT_DSMP(K_DSMP), .CNT_INT(K_INT)) u_swr_link_chk (
		.i_mclk(mclk), .i_sys_rst(rst), .dev_dq_oe(lnk.dev_dq_oe),
		.dev_dq_out(lnk.dev_dq_out), .host_dq_oe(lnk.host_dq_oe),
		.host_dq_out(lnk.host_dq_out), .dq(lnk.dq),
		.dev_int_oe(lnk.dev_int_oe), .dev_int_out(lnk.dev_int_out));

	always #20 mclk = ~mclk;
	// Crystal stand-in: eight clock cycles per period
	always @(posedge mclk) xcnt <= xcnt + 3'h1;
	always @(posedge mclk) if (func_valid === 1'b1) begin
		fseen = 1'b1;
		last_func = func_cmd;
	end

	function automatic logic [7:0] crc_of(input logic [63:0] v,
		input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++)
			c = {1'b0, c[7:1]} ^ ((c[0] ^ v[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic get_rsp();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 30000);
		if (n >= 30000) n_mismatch++;
		r_ok = rsp_ok;
		r_data = rsp_data;
	endtask

	task automatic do_op(input swr_pkg::swr_op_type o, input logic [7:0] d,
		input logic w);
		int n;
		n = 0;
		fseen = 1'b0;
		req_op <= o;
		req_data <= d;
		req_valid <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (req_ready !== 1'b1 && n < 30000);
		req_valid <= 1'b0;
		// Let an edge pass so a following call never re-raises valid at once
		@(posedge mclk);
		if (w) get_rsp();
	endtask

	task automatic rst_chk();
		rst <= 1'b1;
		repeat (8) @(posedge mclk);
		`CHK("rom", 1'b0, rom_ok)
		`CHK("sec", 32'h0, seconds)
		`CHK("xo", 1'b1, xo)
		`CHK("rdy", 1'b0, req_ready)
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	task automatic sec_run(input logic en, input logic [2:0] sel,
		input int k, input int cnt);
		logic [31:0] prev;
		logic        hit;
		int          n;
		int_en <= en;
		int_sel <= sel;
		for (int j = 0; j < cnt; j++) begin
			prev = seconds;
			n = 0;
			while (seconds === prev && n < 100) begin
				@(posedge mclk);
				n++;
			end
			`CHK("sec", prev + 32'h1, seconds)
			hit = 1'b0;
			repeat (16) begin
				@(posedge mclk);
				hit |= int_act;
			end
			`CHK("int", en && ((seconds & ((32'h1 << k) - 1)) == 0), hit)
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		mclk = 0; rst = 1; xcnt = 3'h0; req_valid = 0; req_data = 8'h00;
		req_op = swr_pkg::OP_RESET; rsp_rdy = 1; int_en = 1; int_sel = 3'h0;
		id_exp = {crc_of({8'h00, SER, FAM}, 56), SER, FAM};
		rst_chk();
		foreach (rows[i]) begin
			do_op(rows[i].op, rows[i].d, 1'b1);
			`CHK("ok", rows[i].ok, r_ok)
			if (rows[i].dsel == 2'h1) `CHK("data", 64'h0, r_data)
			if (rows[i].dsel == 2'h2) begin
				`CHK("id", id_exp, r_data)
				`CHK("resid", 8'h00, crc_of(r_data, 64))
			end
			if (rows[i].dsel == 2'h3) `CHK("byte", 8'hff, r_data[7:0])
			`CHK("rom", rows[i].rom, rom_ok)
			`CHK("fseen", rows[i].fchk, fseen)
			if (rows[i].fchk) `CHK("func", rows[i].d, last_func)
		end
		// Hold the reader off: two refusals fill the buffer, a third stalls
		rsp_rdy <= 1'b0;
		do_op(swr_pkg::OP_WRITE, 8'h01, 1'b0);
		do_op(swr_pkg::OP_WRITE, 8'h02, 1'b0);
		req_valid <= 1'b1;
		repeat (20) @(posedge mclk);
		`CHK("stall", 1'b0, req_ready)
		req_valid <= 1'b0;
		rsp_rdy <= 1'b1;
		repeat (2) begin
			get_rsp();
			`CHK("refuse", 1'b0, r_ok)
		end
		sec_run(1'b1, 3'h0, 0, 3);
		sec_run(1'b1, 3'h1, 2, 6);
		sec_run(1'b1, 3'h2, 5, 34);
		sec_run(1'b0, 3'h0, 0, 3);
		do_op(swr_pkg::OP_RESET, 8'h00, 1'b1);
		do_op(swr_pkg::OP_WRITE, 8'hcc, 1'b1);
		`CHK("rom", 1'b1, rom_ok)
		rst_chk();
		conclude();
	end

	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		conclude();
	end
endmodule

//--- testbench/swr_link_chk.sv
// Checker on the open-drain link between master and device ends
module swr_link_chk #(
	parameter int CNT_RST      = 400,
	parameter int CNT_LOW1     = 4,
	parameter int CNT_LOW0     = 40,
	parameter int CNT_RST_DET  = 250,
	parameter int CNT_PRES_DLY = 20,
	parameter int CNT_PRES     = 80,
	parameter int CNT_DSMP     = 20,
	parameter int CNT_INT      = 10
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic dev_dq_oe,
	input wire logic dev_dq_out,
	input wire logic host_dq_oe,
	input wire logic host_dq_out,
	input wire logic dq,
	input wire logic dev_int_oe,
	input wire logic dev_int_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Window allows for edge detection lag on either end
	localparam int PD_LO = CNT_PRES_DLY - 2;
	localparam int PD_HI = CNT_PRES_DLY + 4;
	logic [15:0] dev_run_q, host_run_q, int_run_q, low_run_q;
	logic        pres_q;

	// ****************************************
	// Run-length helpers
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			dev_run_q  <= 16'h0;
			host_run_q <= 16'h0;
			int_run_q  <= 16'h0;
			low_run_q  <= 16'h0;
			pres_q     <= 1'b0;
		end else begin
			dev_run_q  <= dev_dq_oe ? dev_run_q + 16'h1 : 16'h0;
			host_run_q <= host_dq_oe ? host_run_q + 16'h1 : 16'h0;
			int_run_q  <= dev_int_oe ? int_run_q + 16'h1 : 16'h0;
			low_run_q  <= !dq ? low_run_q + 16'h1 : 16'h0;
			// A pull that starts with the master idle is a presence
			pres_q     <= dev_dq_oe ? pres_q : !host_dq_oe;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	dev_pull_only_a: assert property (dev_dq_oe |-> !dev_dq_out)
		else $error("device drives data high");
	host_pull_only_a: assert property (host_dq_oe |-> !host_dq_out)
		else $error("master drives data high");
	int_pull_only_a: assert property (dev_int_oe |-> !dev_int_out)
		else $error("interrupt driven high");
	pres_width_a: assert property ($fell(dev_dq_oe) && pres_q
		|-> dev_run_q == CNT_PRES) else $error("presence width wrong");
	slot_width_a: assert property ($fell(dev_dq_oe) && !pres_q
		|-> dev_run_q < CNT_DSMP + 2) else $error("slot pull too long");
	pres_delay_a: assert property ($rose(dq) && low_run_q >= CNT_RST_DET
		|-> ##[PD_LO:PD_HI] $rose(dev_dq_oe))
		else $error("presence not in window");
	host_pulse_a: assert property ($fell(host_dq_oe) |->
		host_run_q inside {CNT_LOW1, CNT_LOW0, CNT_RST})
		else $error("master pulse width wrong");
	int_width_a: assert property ($fell(dev_int_oe)
		|-> int_run_q == CNT_INT) else $error("interrupt width wrong");
	rst_quiet_a: assert property ($fell(i_sys_rst)
		|-> !dev_dq_oe && !host_dq_oe && !dev_int_oe)
		else $error("line pulled after reset");
endmodule
